/* common/scm_consts.svh */
// Constants of the serial channel clock and mode setup block.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef SCM_CONSTS_SVH
`define SCM_CONSTS_SVH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define SCM_OFS_PCLK_EN   8'h00
`define SCM_OFS_PRESCALE  8'h04
`define SCM_OFS_CH_MODE   8'h08
`define SCM_OFS_CTRL      8'h0C
`define SCM_OFS_STATUS    8'h10
`define SCM_OFS_XDIV      8'h14

// ----------------------------------------
// Field positions
// ----------------------------------------
`define SCM_PCLK_UNIT_BIT 2
`define SCM_PCLK_RSVD_MASK 8'hBD
`define SCM_PRE0_LSB 0
`define SCM_PRE1_LSB 4
`define SCM_MODE_OPCLK_BIT 15
`define SCM_MODE_XCLK_BIT 14
`define SCM_MODE_TRIG_BIT 8
`define SCM_MODE_INV_BIT 6
`define SCM_MODE_FIX1_BIT 5
`define SCM_MODE_MD_HI 2
`define SCM_MODE_MD_LO 1
`define SCM_MODE_IRQ_BIT 0
`define SCM_MODE_RW_MASK 16'hC141
`define SCM_CTRL_START_BIT 0
`define SCM_CTRL_STOP_BIT 1
`define SCM_CTRL_CLRERR_BIT 2
`define SCM_MODE_PROHIBITED 2'h3

// ----------------------------------------
// Reset values
// ----------------------------------------
`define SCM_RST_PCLK_EN  8'h00
`define SCM_RST_PRESCALE 8'h00
`define SCM_RST_CH_MODE  16'h0020
`define SCM_RST_XDIV     8'h00

// ----------------------------------------
// Counts
// ----------------------------------------
`define SCM_PRE_BITS 15

`endif

/* common/scm_pkg.sv */
// Types shared by the serial channel clock and mode setup block.
// Assumes the constants header sits beside it on the include path.
package scm_pkg;
	`include "scm_consts.svh"

	// Channel operating modes, in field order
	typedef enum logic [1:0] {
		SCM_MODE_CLOCKED,
		SCM_MODE_UART,
		SCM_MODE_SIMPLE_I2C,
		SCM_MODE_BAD
	} scm_mode_e;

	// Channel run states
	typedef enum logic [1:0] {
		SCM_ST_IDLE,
		SCM_ST_WAIT_EDGE,
		SCM_ST_RUN
	} scm_state_e;

	// Prescaler field type
	typedef logic [3:0] scm_div_t;
endpackage

/* hw/scm_channel.sv */
// Serial channel clock gating, prescaler and mode setup, with register port.
// Assumes a same-clock register master and asynchronous receive and clock pins.
//
// The register addresses and strobed register access are this design's own decisions.
`include "scm_consts.svh"
module scm_channel (
	input wire logic clk,
	input wire logic reset,
	input wire logic [7:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [15:0] reg_rdata,
	input wire logic rx_pin,
	input wire logic sck_pin,
	input wire logic xfer_end_evt,
	input wire logic buf_empty_evt,
	output logic unit_clk_en,
	output logic op_clk_tick,
	output logic transfer_clock,
	output logic chan_run,
	output logic [1:0] chan_mode,
	output logic chan_irq
);
	// ----------------------------------------
	// Register state
	// ----------------------------------------
	logic [7:0] pclk_r; // Peripheral clock enable
	logic [7:0] pclk_nxt;
	logic [7:0] pre_r; // Prescaler select
	logic [7:0] pre_nxt;
	logic [15:0] mode_r; // Channel mode
	logic [15:0] mode_nxt;
	logic [7:0] xdiv_r; // Transfer clock divisor minus one
	logic [7:0] xdiv_nxt;
	logic bad_r; // Sticky: prohibited mode written
	logic bad_nxt;
	logic [15:0] rdata_r; // Read data, one cycle after strobe
	logic [15:0] rdata_nxt;

	// Decoded controls
	logic serial_unit_clock_enable;
	logic op_clock_select;
	logic transfer_clock_select;
	logic start_trigger_select;
	logic rx_level_invert;
	logic mode_field_high;
	logic mode_field_low;
	logic irq_source_select;
	logic sw_start;
	logic sw_stop;
	// Synchronised pins and prescaler pulses; the receive level is read by the status path too
	logic rx_level;
	logic rx_rise;
	logic rx_fall;
	logic sck_rise;
	logic pre_tick0;
	logic pre_tick1;

	// Address match for a write
	function automatic logic wr_hit(input logic [7:0] ofs);
		wr_hit = reg_wr && (reg_addr == ofs);
	endfunction

	assign serial_unit_clock_enable = pclk_r[`SCM_PCLK_UNIT_BIT];
	assign op_clock_select = mode_r[`SCM_MODE_OPCLK_BIT];
	assign transfer_clock_select = mode_r[`SCM_MODE_XCLK_BIT];
	assign start_trigger_select = mode_r[`SCM_MODE_TRIG_BIT];
	assign rx_level_invert = mode_r[`SCM_MODE_INV_BIT];
	assign mode_field_high = mode_r[`SCM_MODE_MD_HI];
	assign mode_field_low = mode_r[`SCM_MODE_MD_LO];
	assign irq_source_select = mode_r[`SCM_MODE_IRQ_BIT];
	// Written out in full: a continuous assignment only follows its own operands
	assign sw_start = reg_wr && (reg_addr == `SCM_OFS_CTRL) && reg_wdata[`SCM_CTRL_START_BIT];
	assign sw_stop = reg_wr && (reg_addr == `SCM_OFS_CTRL) && reg_wdata[`SCM_CTRL_STOP_BIT];

	// ----------------------------------------
	// Register writes and reads
	// ----------------------------------------
	always_comb
	begin
		pclk_nxt = pclk_r;
		pre_nxt = pre_r;
		mode_nxt = mode_r;
		xdiv_nxt = xdiv_r;
		bad_nxt = bad_r;
		rdata_nxt = 16'h0000;
		// Reserved enable bits stay zero
		if (wr_hit(`SCM_OFS_PCLK_EN))
			pclk_nxt = reg_wdata[7:0] & `SCM_PCLK_RSVD_MASK;
		if (wr_hit(`SCM_OFS_PRESCALE))
			pre_nxt = reg_wdata[7:0];
		if (wr_hit(`SCM_OFS_XDIV))
			xdiv_nxt = reg_wdata[7:0];
		if (wr_hit(`SCM_OFS_CH_MODE))
		begin
			// Fixed bits keep their value, the one bit reads one
			mode_nxt = (reg_wdata & `SCM_MODE_RW_MASK) | `SCM_RST_CH_MODE;
			mode_nxt[`SCM_MODE_MD_HI:`SCM_MODE_MD_LO] = reg_wdata[`SCM_MODE_MD_HI:`SCM_MODE_MD_LO];
			// Prohibited mode is refused; old mode stays, error flagged
			if (reg_wdata[`SCM_MODE_MD_HI:`SCM_MODE_MD_LO] == `SCM_MODE_PROHIBITED)
			begin
				mode_nxt[`SCM_MODE_MD_HI:`SCM_MODE_MD_LO] = mode_r[`SCM_MODE_MD_HI:`SCM_MODE_MD_LO];
			end
		end
		// Clear first, so a refused write in the same cycle wins
		if (wr_hit(`SCM_OFS_CTRL) && reg_wdata[`SCM_CTRL_CLRERR_BIT])
			bad_nxt = 1'b0;
		if (wr_hit(`SCM_OFS_CH_MODE)
			&& reg_wdata[`SCM_MODE_MD_HI:`SCM_MODE_MD_LO] == `SCM_MODE_PROHIBITED)
			bad_nxt = 1'b1;
		if (reg_rd)
		begin
			case (reg_addr)
				`SCM_OFS_PCLK_EN: rdata_nxt = {8'h00, pclk_r};
				`SCM_OFS_PRESCALE: rdata_nxt = {8'h00, pre_r};
				`SCM_OFS_CH_MODE: rdata_nxt = mode_r;
				`SCM_OFS_XDIV: rdata_nxt = {8'h00, xdiv_r};
				`SCM_OFS_STATUS: rdata_nxt = {11'h000, rx_level, bad_r, chan_mode, chan_run};
				// Control is write-only, unmapped reads zero
				default: rdata_nxt = 16'h0000;
			endcase
		end
	end

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			pclk_r <= `SCM_RST_PCLK_EN;
			pre_r <= `SCM_RST_PRESCALE;
			mode_r <= `SCM_RST_CH_MODE;
			xdiv_r <= `SCM_RST_XDIV;
			bad_r <= 1'b0;
			rdata_r <= 16'h0000;
		end
		else
		begin
			pclk_r <= pclk_nxt;
			pre_r <= pre_nxt;
			mode_r <= mode_nxt;
			xdiv_r <= xdiv_nxt;
			bad_r <= bad_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	// ----------------------------------------
	// Pin synchronisers and prescaler
	// ----------------------------------------
	scm_sync_edge u_rx_sync (
		.clk(clk),
		.reset(reset),
		.pin(rx_pin),
		.level(rx_level),
		.rise(rx_rise),
		.fall(rx_fall)
	);
	scm_sync_edge u_sck_sync (
		.clk(clk),
		.reset(reset),
		.pin(sck_pin),
		.level(),
		.rise(sck_rise),
		.fall()
	);

	// Whole prescaler count parks at zero, with no ticks, while the unit clock is gated
	scm_prescaler u_pre (
		.clk(clk),
		.reset(reset),
		.enable(serial_unit_clock_enable),
		.div0(pre_r[`SCM_PRE0_LSB +: 4]),
		.div1(pre_r[`SCM_PRE1_LSB +: 4]),
		.tick0(pre_tick0),
		.tick1(pre_tick1)
	);

	// ----------------------------------------
	// Operation and transfer clocks
	// ----------------------------------------
	logic op_r; // Selected operation clock pulse
	logic op_nxt;
	logic [7:0] xcnt_r; // Operation pulses since last transfer pulse
	logic [7:0] xcnt_nxt;
	logic xclk_r; // Transfer clock pulse
	logic xclk_nxt;

	always_comb
	begin
		op_nxt = op_clock_select ? pre_tick1 : pre_tick0;
		xcnt_nxt = xcnt_r;
		xclk_nxt = 1'b0;
		if (!serial_unit_clock_enable)
		begin
			// No supply: pin clock is ignored too
			xcnt_nxt = 8'h00;
		end
		else if (transfer_clock_select)
		begin
			// External clock pin, rising edge per transfer pulse
			xcnt_nxt = 8'h00;
			xclk_nxt = sck_rise;
		end
		else if (op_r)
		begin
			// Divide operation pulses by divisor plus one
			if (xcnt_r >= xdiv_r)
			begin
				xcnt_nxt = 8'h00;
				xclk_nxt = 1'b1;
			end
			else
				xcnt_nxt = xcnt_r + 8'h01;
		end
	end

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			op_r <= 1'b0;
			xcnt_r <= 8'h00;
			xclk_r <= 1'b0;
		end
		else
		begin
			op_r <= op_nxt;
			xcnt_r <= xcnt_nxt;
			xclk_r <= xclk_nxt;
		end
	end

	// ----------------------------------------
	// Start control
	// ----------------------------------------
	scm_pkg::scm_state_e st_r;
	scm_pkg::scm_state_e st_nxt;
	logic uart_mode;
	logic start_edge;

	assign uart_mode = {mode_field_high, mode_field_low} == scm_pkg::SCM_MODE_UART;
	// Polarity choice only in UART mode; elsewhere falling edge
	assign start_edge = (uart_mode && rx_level_invert) ? rx_rise : rx_fall;

	always_comb
	begin
		st_nxt = st_r;
		case (st_r)
			scm_pkg::SCM_ST_IDLE:
				if (sw_start)
					st_nxt = start_trigger_select ? scm_pkg::SCM_ST_WAIT_EDGE : scm_pkg::SCM_ST_RUN;
			scm_pkg::SCM_ST_WAIT_EDGE:
				if (start_edge)
					st_nxt = scm_pkg::SCM_ST_RUN;
			scm_pkg::SCM_ST_RUN:
				st_nxt = scm_pkg::SCM_ST_RUN;
			default:
				st_nxt = scm_pkg::SCM_ST_IDLE;
		endcase
		// Stop or loss of unit clock halts the channel
		if (sw_stop || !serial_unit_clock_enable)
			st_nxt = scm_pkg::SCM_ST_IDLE;
	end

	// ----------------------------------------
	// Interrupt source
	// ----------------------------------------
	logic irq_r;
	logic irq_nxt;

	always_comb
	begin
		// Only a running channel reports events
		irq_nxt = (st_r == scm_pkg::SCM_ST_RUN)
			&& (irq_source_select ? buf_empty_evt : xfer_end_evt);
	end

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			st_r <= scm_pkg::SCM_ST_IDLE;
			irq_r <= 1'b0;
		end
		else
		begin
			st_r <= st_nxt;
			irq_r <= irq_nxt;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign reg_rdata = rdata_r;
	assign unit_clk_en = serial_unit_clock_enable;
	assign op_clk_tick = op_r;
	assign transfer_clock = xclk_r;
	assign chan_run = (st_r == scm_pkg::SCM_ST_RUN);
	assign chan_mode = {mode_field_high, mode_field_low};
	assign chan_irq = irq_r;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	sequence s_waiting;
		st_r == scm_pkg::SCM_ST_WAIT_EDGE && serial_unit_clock_enable && !sw_stop;
	endsequence
	sequence s_rx_rise_uart_inv;
		s_waiting ##0 uart_mode && rx_level_invert && rx_rise;
	endsequence
	// Gated cycle forces the next tick low; a quick re-enable may tick again after that
	chk_gate_stops_ticks: assert property (!serial_unit_clock_enable |=> !pre_tick0 && !pre_tick1)
		else $error("prescaler ticks while unit clock gated");
	chk_div_zero_every: assert property (serial_unit_clock_enable && $past(serial_unit_clock_enable)
		&& pre_r[3:0] == 4'h0 && $past(pre_r[3:0]) == 4'h0 |-> pre_tick0)
		else $error("undivided prescaler output missed a cycle");
	chk_div_one_spacing: assert property (pre_tick0 && pre_r[3:0] == 4'h1 && $past(pre_r[3:0]) == 4'h1
		|=> !pre_tick0)
		else $error("half rate output pulsed twice in a row");
	chk_op_select: assert property ($past(serial_unit_clock_enable) && op_clock_select
		&& $past(op_clock_select) |-> op_r == $past(pre_tick1))
		else $error("operation clock not from output one");
	chk_ext_clock: assert property (serial_unit_clock_enable && transfer_clock_select && sck_rise
		|=> xclk_r)
		else $error("pin clock edge gave no transfer pulse");
	chk_sw_start: assert property (st_r == scm_pkg::SCM_ST_IDLE && sw_start && !sw_stop
		&& serial_unit_clock_enable && !start_trigger_select |=> chan_run)
		else $error("software start did not run channel");
	chk_edge_wait: assert property (s_waiting ##0 !start_edge |=> !chan_run)
		else $error("channel ran without start edge");
	chk_rise_start: assert property (s_rx_rise_uart_inv |=> chan_run)
		else $error("inverted UART start edge ignored");
	// Address test written out, so the property sees sampled strobe values
	chk_bad_mode: assert property (reg_wr && reg_addr == `SCM_OFS_CH_MODE
		&& reg_wdata[2:1] == `SCM_MODE_PROHIBITED |=> chan_mode == $past(chan_mode) && bad_r)
		else $error("prohibited mode accepted");
	chk_irq_source: assert property (chan_run && !irq_source_select && xfer_end_evt
		|=> chan_irq)
		else $error("transfer end interrupt missed");
endmodule

/* hw/scm_prescaler.sv */
// Prescaler: two power-of-two enable pulses derived from the system clock.
// Assumes its enable comes from the unit clock gate on the same clock.
`include "scm_consts.svh"
module scm_prescaler (
	input wire logic clk,
	input wire logic reset,
	input wire logic enable,
	input wire scm_pkg::scm_div_t div0,
	input wire scm_pkg::scm_div_t div1,
	output logic tick0,
	output logic tick1
);
	logic [`SCM_PRE_BITS-1:0] cnt_r; // Free running count
	logic [`SCM_PRE_BITS-1:0] cnt_nxt;
	logic tick0_r;
	logic tick0_nxt;
	logic tick1_r;
	logic tick1_nxt;

	// One pulse every 2**k cycles: low k count bits all ones
	function automatic logic div_hit(input logic [`SCM_PRE_BITS-1:0] cnt, input scm_pkg::scm_div_t k);
		logic [`SCM_PRE_BITS-1:0] mask;
		mask = ~({`SCM_PRE_BITS{1'b1}} << k);
		div_hit = ((cnt & mask) == mask);
	endfunction

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb
	begin
		// Gated off: count parks at zero, no pulses
		cnt_nxt = enable ? cnt_r + 1'b1 : '0;
		tick0_nxt = enable & div_hit(cnt_r, div0);
		tick1_nxt = enable & div_hit(cnt_r, div1);
	end

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			cnt_r <= '0;
			tick0_r <= 1'b0;
			tick1_r <= 1'b0;
		end
		else
		begin
			cnt_r <= cnt_nxt;
			tick0_r <= tick0_nxt;
			tick1_r <= tick1_nxt;
		end
	end

	assign tick0 = tick0_r;
	assign tick1 = tick1_r;
endmodule

/* hw/scm_sync_edge.sv */
// Two-flop synchroniser for one pin, with rising and falling edge pulses.
// Assumes the pin is asynchronous to clk; edges come from the second flop onward.
module scm_sync_edge (
	input wire logic clk,
	input wire logic reset,
	input wire logic pin,
	output logic level,
	output logic rise,
	output logic fall
);
	logic meta_r; // First flop, read only by the second
	logic sync_r; // Settled level
	logic prev_r; // Level one cycle back, for edges

	// ----------------------------------------
	// Synchroniser chain
	// ----------------------------------------
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			meta_r <= 1'b1;
			sync_r <= 1'b1;
			prev_r <= 1'b1;
		end
		else
		begin
			meta_r <= pin;
			sync_r <= meta_r;
			prev_r <= sync_r;
		end
	end

	// Idle line is high, so reset to high avoids a false falling edge
	assign level = sync_r;
	assign rise = sync_r & ~prev_r;
	assign fall = ~sync_r & prev_r;
endmodule

/* tb/scm_uart_peer.sv */
// Remote UART peer: drives the receive data line and the serial clock pin.
// Assumes the bench calls one task at a time; pins are asynchronous to clk.
module scm_uart_peer #(
	parameter int BIT_NS = 800,
	parameter int SCK_NS = 100
) (
	output logic rx_pin,
	output logic sck_pin
);
	timeunit 1ns;
	timeprecision 1ps;

	// ----------------------------------------
	// Line levels
	// ----------------------------------------
	// Pulled-up line idles high; clock stands still outside pulse bursts
	initial
	begin
		rx_pin = 1'b1;
		sck_pin = 1'b0;
	end

	// Idle level, low for an inverted line
	task automatic set_idle(input logic lvl);
		rx_pin = lvl;
	endtask

	// Start bit, eight data bits lsb first, stop bit
	task automatic send_frame(input logic [7:0] data, input logic inv);
		logic [9:0] bits;
		bits = {1'b1, data, 1'b0};
		for (int i = 0; i < 10; i++)
		begin
			rx_pin = bits[i] ^ inv;
			#(BIT_NS);
		end
	endtask

	// Burst of external clock pulses, then still again
	task automatic clock_pulses(input int n);
		repeat (n)
		begin
			sck_pin = 1'b1;
			#(SCK_NS);
			sck_pin = 1'b0;
			#(SCK_NS);
		end
	endtask
endmodule

/* tb/test_serial_channel_clock_mode_setup.sv */
// Self-checking bench for the channel clock gating, prescaler and mode setup.
// Assumes the package, the channel design and the peer model are compiled first.
module test_serial_channel_clock_mode_setup;
	timeunit 1ns;
	timeprecision 1ps;
	`include "scm_consts.svh"

	// ----------------------------------------
	// Signals and model state
	// ----------------------------------------
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic [7:0] reg_addr = 8'h00;
	logic [15:0] reg_wdata = 16'h0000;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [15:0] reg_rdata;
	logic rx_pin;
	logic sck_pin;
	logic xfer_end_evt = 1'b0;
	logic buf_empty_evt = 1'b0;
	logic unit_clk_en;
	logic op_clk_tick;
	logic transfer_clock;
	logic chan_run;
	logic [1:0] chan_mode;
	logic chan_irq;
	int num_errors = 0;
	int num_checks = 0;
	// Register model
	int m_en = 0;
	int m_pre = 0;
	int m_mode = 16'h0020;
	int m_xdiv = 0;
	int m_run = 0;
	int m_bad = 0;
	int cnt;
	int k;
	int d;
	int n;
	logic [7:0] ofs [6] = '{`SCM_OFS_PCLK_EN, `SCM_OFS_PRESCALE, `SCM_OFS_CH_MODE, `SCM_OFS_XDIV,
		`SCM_OFS_STATUS, 8'h18};

	always #20 clk = ~clk;

	scm_channel scm_channel_inst (.clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_pin(rx_pin), .sck_pin(sck_pin),
		.xfer_end_evt(xfer_end_evt), .buf_empty_evt(buf_empty_evt), .unit_clk_en(unit_clk_en),
		.op_clk_tick(op_clk_tick), .transfer_clock(transfer_clock), .chan_run(chan_run),
		.chan_mode(chan_mode), .chan_irq(chan_irq));
	scm_uart_peer scm_uart_peer_inst (.rx_pin(rx_pin), .sck_pin(sck_pin));

	// ----------------------------------------
	// Compare, bus and event tasks
	// ----------------------------------------
	task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp, input string what);
		num_checks++;
		if (got !== exp)
		begin
			num_errors++;
			$display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	task automatic cmp_flag(input logic got, input logic exp, input string what);
		num_checks++;
		if (got !== exp)
		begin
			num_errors++;
			$display("MISMATCH at %0t: %s got %b expected %b", $time, what, got, exp);
		end
	endtask

	// Expected read value per address; unmapped reads 0
	function automatic logic [15:0] model_val(input logic [7:0] a);
		case (a)
			`SCM_OFS_PCLK_EN: return {8'h00, m_en[7:0]};
			`SCM_OFS_PRESCALE: return {8'h00, m_pre[7:0]};
			`SCM_OFS_CH_MODE: return m_mode[15:0];
			`SCM_OFS_XDIV: return {8'h00, m_xdiv[7:0]};
			// Status: synced receive level, sticky mode error, mode, run
			`SCM_OFS_STATUS: return {11'h000, rx_pin, m_bad[0], m_mode[2:1], m_run[0]};
			default: return 16'h0000;
		endcase
	endfunction

	// One-cycle write, then the model follows; returns with outputs settled
	task automatic reg_write(input logic [7:0] a, input logic [15:0] v);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		case (a)
			`SCM_OFS_PCLK_EN: m_en = v[7:0] & 8'hbd;
			`SCM_OFS_PRESCALE: m_pre = v[7:0];
			`SCM_OFS_XDIV: m_xdiv = v[7:0];
			// Prohibited field keeps the old mode
			`SCM_OFS_CH_MODE:
			begin
				m_bad = m_bad | (v[2:1] == 2'b11);
				m_mode = (v & 16'hc141) | 16'h0020 | ((v[2:1] == 2'b11) ? (m_mode & 6) : (v & 6));
			end
			`SCM_OFS_CTRL:
			begin
				m_run = v[1] ? 0 : (v[0] && m_en[2] && !m_mode[8]) ? 1 : m_run;
				if (v[2])
					m_bad = 0;
			end
			default: ;
		endcase
		if (!m_en[2])
			m_run = 0;
		#1;
	endtask

	// Read strobe, data sampled in the following cycle only
	task automatic check_reg(input logic [7:0] a);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		cmp_word(reg_rdata, model_val(a), "register read");
	endtask

	// Samples just after each edge, where the registered pulses have settled
	task automatic count_pulses(input int sel, input int cycles, output int c);
		c = 0;
		repeat (cycles)
		begin
			#1;
			c += ((sel == 0) ? op_clk_tick : (sel == 1) ? transfer_clock : chan_irq) === 1'b1;
			@(posedge clk);
		end
	endtask

	task automatic evt_pulse(input int which);
		@(posedge clk);
		xfer_end_evt <= (which == 0);
		buf_empty_evt <= (which == 1);
		@(posedge clk);
		xfer_end_evt <= 1'b0;
		buf_empty_evt <= 1'b0;
	endtask

	task automatic conclude();
		$display("Checks %0d, mismatches %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// ----------------------------------------
	// Tests
	// ----------------------------------------
	// Watchdog well beyond the one to two thousand cycles the tests need
	initial
	begin
		#2400000;
		num_errors++;
		$display("MISMATCH at %0t: run did not finish", $time);
		conclude();
	end

	initial
	begin
		void'($urandom(55));
		repeat (3) @(posedge clk);
		reset <= 1'b0;
		foreach (ofs[i]) check_reg(ofs[i]);
		$display("Reset values done");
		reg_write(`SCM_OFS_PCLK_EN, 16'h00ff);
		check_reg(`SCM_OFS_PCLK_EN);
		cmp_flag(unit_clk_en, 1'b1, "unit clock");
		// Both prescaler outputs, random divides; output zero at divide by two first
		for (int s = 0; s < 4; s++)
		begin
			k = (s == 0) ? 1 : $urandom % 4;
			d = $urandom % 4;
			reg_write(`SCM_OFS_PRESCALE, s[0] ? {8'h00, k[3:0], 4'h0} : {12'h000, k[3:0]});
			reg_write(`SCM_OFS_XDIV, d[15:0]);
			reg_write(`SCM_OFS_CH_MODE, {s[0], 15'h0002});
			check_reg(`SCM_OFS_PRESCALE);
			repeat (40) @(posedge clk);
			count_pulses(0, 16 << k, cnt);
			cmp_word(cnt[15:0], 16'd16, "operation ticks");
			count_pulses(1, 8 * (d + 1) << k, cnt);
			cmp_word(cnt[15:0], 16'd8, "divided transfer ticks");
		end
		// Transfer clock from the pin
		reg_write(`SCM_OFS_CH_MODE, 16'h4002);
		n = 1 + $urandom % 5;
		fork
			scm_uart_peer_inst.clock_pulses(n);
			// Skip the pulse still launched by the divided clock at the mode write
			begin
				@(posedge clk);
				count_pulses(1, n * 5 + 12, cnt);
			end
		join
		cmp_word(cnt[15:0], n[15:0], "pin transfer ticks");
		$display("Clock selection done");
		// Every mode code, the prohibited one last
		for (int m = 0; m < 4; m++)
		begin
			reg_write(`SCM_OFS_CH_MODE, 16'(m << 1));
			cmp_word({14'h0000, chan_mode}, {14'h0000, m_mode[2:1]}, "mode field");
			check_reg(`SCM_OFS_CH_MODE);
		end
		check_reg(`SCM_OFS_STATUS);
		reg_write(`SCM_OFS_CTRL, 16'h0004);
		check_reg(`SCM_OFS_STATUS);
		$display("Mode codes done");
		// Software start, then both interrupt sources
		reg_write(`SCM_OFS_CH_MODE, 16'h0000);
		reg_write(`SCM_OFS_CTRL, 16'h0001);
		cmp_flag(chan_run, m_run[0], "software start");
		check_reg(`SCM_OFS_STATUS);
		for (int src = 0; src < 2; src++)
		begin
			reg_write(`SCM_OFS_CH_MODE, 16'(src));
			for (int ev = 0; ev < 2; ev++)
			begin
				evt_pulse(ev);
				count_pulses(2, 3, cnt);
				cmp_word(cnt[15:0], {15'h0000, src == ev}, "interrupt source");
			end
		end
		reg_write(`SCM_OFS_CTRL, 16'h0002);
		cmp_flag(chan_run, m_run[0], "stop");
		$display("Software start and interrupts done");
		// Start on the receive line edge, both polarities
		for (int inv = 0; inv < 2; inv++)
		begin
			scm_uart_peer_inst.set_idle(!inv[0]);
			repeat (8) @(posedge clk);
			reg_write(`SCM_OFS_CH_MODE, 16'h0102 | 16'(inv << 6));
			reg_write(`SCM_OFS_CTRL, 16'h0001);
			repeat (8) @(posedge clk);
			cmp_flag(chan_run, 1'b0, "waiting for edge");
			fork
				scm_uart_peer_inst.send_frame(8'($urandom), inv[0]);
				begin
					repeat (8) @(posedge clk);
					m_run = 1;
					cmp_flag(chan_run, m_run[0], "edge start");
				end
			join
			reg_write(`SCM_OFS_CTRL, 16'h0002);
		end
		scm_uart_peer_inst.set_idle(1'b1);
		$display("Edge start done");
		// Gating off stops ticks and the channel; start then refused
		reg_write(`SCM_OFS_CH_MODE, 16'h0002);
		reg_write(`SCM_OFS_CTRL, 16'h0001);
		reg_write(`SCM_OFS_PCLK_EN, 16'h0000);
		cmp_flag(unit_clk_en, 1'b0, "unit clock off");
		repeat (2) @(posedge clk);
		count_pulses(0, 32, cnt);
		cmp_word(cnt[15:0], 16'd0, "ticks while gated");
		reg_write(`SCM_OFS_CTRL, 16'h0001);
		cmp_flag(chan_run, m_run[0], "start while gated");
		$display("Clock gating done");
		// Reset in mid-run brings every register back to its reset value
		@(posedge clk);
		reset <= 1'b1;
		repeat (3) @(posedge clk);
		reset <= 1'b0;
		m_en = 0;
		m_pre = 0;
		m_mode = 16'h0020;
		m_xdiv = 0;
		m_run = 0;
		m_bad = 0;
		foreach (ofs[i]) check_reg(ofs[i]);
		$display("Mid-run reset done");
		conclude();
	end
endmodule
